// ===== hw/parallel_config_params.svh
// Offsets, field positions, reset values and codes of the parallel config loader
`ifndef PARALLEL_CONFIG_PARAMS_SVH
`define PARALLEL_CONFIG_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_WORD        12'h008
`define OFS_COUNT       12'h00C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_ENABLE_BIT  0
`define CTRL_DECOMP_BIT  1
`define CTRL_DECRYPT_BIT 2
`define STAT_WIDTH_LSB   0
`define STAT_BUSY_BIT    2
`define STAT_RATIO_LSB   8
`define STAT_PHASE_LSB   12

// ----------------------------------------------------------------
// Reset values, width codes and ratio codes
// ----------------------------------------------------------------
`define CTRL_RESET      3'h0
`define WIDTH_8         2'h0
`define WIDTH_16        2'h1
`define WIDTH_32        2'h2
`define RATIO_1         4'h1
`define RATIO_2         4'h2
`define RATIO_4         4'h4
`define RATIO_8         4'h8

`endif

// ===== hw/parallel_config_pkg.sv
// Types shared by the parallel config loader
`default_nettype none
package parallel_config_pkg;

  // ----------------------------------------------------------------
  // Latched configuration word as handed to the core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } cfg_word_type;

  // ----------------------------------------------------------------
  // Whole state of the loader
  // ----------------------------------------------------------------
  typedef struct packed {
    logic         clk_s1;
    logic         clk_s2;
    logic         clk_s3;
    logic [31:0]  data_s1;
    logic [31:0]  data_s2;
    logic [1:0]   strap_s1;
    logic [1:0]   strap_s2;
    logic [1:0]   strap_wait;
    logic         strap_done;
    logic [1:0]   width;
    logic [2:0]   ctrl;
    logic [3:0]   phase;
    cfg_word_type word;
    logic [31:0]  count;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         busy;
  } state_type;

endpackage : parallel_config_pkg

`default_nettype wire

// ===== hw/parallel_config_clock_ratio.sv
// Passive parallel configuration intake with clock-to-word ratio and APB registers
//
// Function
// - Clock-to-word ratio follows width and features; both features off gives ratio 1.
// - x16: decrypt 2, decompress 4; x32: decrypt 4, decompress 8; x8 decompress 2.
// - One word latched per r clock cycles; the other r-1 cycles process it.
// - x8 uses lanes 7..0, x16 lanes 15..0; unused lanes are dropped.
// - Bus width comes from the mode select straps.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "parallel_config_params.svh"

module parallel_config_clock_ratio
  import parallel_config_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         config_clock,
  input  wire logic [31:0]  config_data,
  input  wire logic [1:0]   mode_select_straps,
  output cfg_word_type      cfg_word,
  output logic              busy
);

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  state_type st_r;
  state_type st_nxt;
  logic [3:0] ratio;
  logic       rise;
  logic       setup;
  logic       access;
  logic       count_clear;

  // Ratio lookup by width and feature enables
  // x8 with decryption only falls back to 1; strap 11 is taken as x32
  function automatic logic [3:0] ratio_of(input logic [1:0] w,
                                          input logic       decomp,
                                          input logic       decrypt);
    logic [3:0] r;
    r = `RATIO_1;
    if (decomp) begin
      case (w)
        `WIDTH_8:  r = `RATIO_2;
        `WIDTH_16: r = `RATIO_4;
        default:   r = `RATIO_8;
      endcase
    end else if (decrypt) begin
      case (w)
        `WIDTH_8:  r = `RATIO_1;
        `WIDTH_16: r = `RATIO_2;
        default:   r = `RATIO_4;
      endcase
    end
    return r;
  endfunction : ratio_of

  // Lane mask per bus width
  function automatic logic [31:0] lanes_of(input logic [1:0]  w,
                                           input logic [31:0] d);
    logic [31:0] m;
    case (w)
      `WIDTH_8:  m = {24'h00_0000, d[7:0]};
      `WIDTH_16: m = {16'h0000, d[15:0]};
      default:   m = d;
    endcase
    return m;
  endfunction : lanes_of

  assign ratio  = ratio_of(st_r.width, st_r.ctrl[`CTRL_DECOMP_BIT],
                           st_r.ctrl[`CTRL_DECRYPT_BIT]);
  // The config clock pin is foreign to pclk: two flops settle it and a third
  // finds its rising edge, so a word is taken about three pclk after the pin
  // rises. The data bus goes through the same two flops, so the host must
  // keep a word stable for at least three pclk around each rising edge.
  assign rise        = st_r.clk_s2 & ~st_r.clk_s3;
  assign setup       = psel & ~penable;
  assign access      = psel & penable & st_r.pready;
  assign count_clear = access & pwrite & (paddr == `OFS_COUNT) & ~st_r.pslverr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.clk_s1   = config_clock;
    st_nxt.clk_s2   = st_r.clk_s1;
    st_nxt.clk_s3   = st_r.clk_s2;
    st_nxt.data_s1  = config_data;
    st_nxt.data_s2  = st_r.data_s1;
    st_nxt.strap_s1 = mode_select_straps;
    st_nxt.strap_s2 = st_r.strap_s1;
    st_nxt.word.valid = 1'b0;

    // Straps are trusted only once both sync stages hold them: wait two
    // edges after reset release, then capture once
    if (st_r.strap_wait != 2'h2) begin
      st_nxt.strap_wait = st_r.strap_wait + 2'h1;
    end else if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.width = (st_r.strap_s2 == `WIDTH_8)  ? `WIDTH_8 :
                     (st_r.strap_s2 == `WIDTH_16) ? `WIDTH_16 : `WIDTH_32;
    end

    // Latch on phase zero, then spend r-1 edges processing
    if (rise && st_r.strap_done && st_r.ctrl[`CTRL_ENABLE_BIT]) begin
      if (st_r.phase == 4'h0) begin
        st_nxt.word.valid = 1'b1;
        st_nxt.word.data  = lanes_of(st_r.width, st_r.data_s2);
        st_nxt.count      = st_r.count + 32'h0000_0001;
      end
      st_nxt.phase = (st_r.phase + 4'h1 >= ratio) ? 4'h0 : st_r.phase + 4'h1;
    end

    // APB answer prepared in the setup cycle
    st_nxt.pready  = setup;
    st_nxt.pslverr = 1'b0;
    if (setup) begin
      st_nxt.prdata = 32'h0000_0000;
      case (paddr)
        `OFS_CTRL:   st_nxt.prdata = {29'h0000_0000, st_r.ctrl};
        `OFS_STATUS: begin
          st_nxt.prdata[`STAT_WIDTH_LSB +: 2] = st_r.width;
          st_nxt.prdata[`STAT_BUSY_BIT]       = (st_r.phase != 4'h0);
          st_nxt.prdata[`STAT_RATIO_LSB +: 4] = ratio;
          st_nxt.prdata[`STAT_PHASE_LSB +: 4] = st_r.phase;
        end
        `OFS_WORD:   st_nxt.prdata = st_r.word.data;
        `OFS_COUNT:  st_nxt.prdata = st_r.count;
        default:     st_nxt.pslverr = 1'b1;
      endcase
    end else begin
      st_nxt.prdata = st_r.prdata;                          // Read data held until next setup
    end

    // Register writes at the access edge
    if (access && pwrite && !st_r.pslverr) begin
      case (paddr)
        `OFS_CTRL: begin
          st_nxt.ctrl  = pwdata[2:0];
          st_nxt.phase = 4'h0;                              // New ratio restarts phase
        end
        `OFS_COUNT: begin
          if (!st_nxt.word.valid) begin
            st_nxt.count = 32'h0000_0000;                   // Latch wins over clear
          end else begin
            st_nxt.count = 32'h0000_0001;
          end
        end
        default: st_nxt.count = st_nxt.count;
      endcase
    end

    // Busy registered from the final phase so the pin is a flop output
    st_nxt.busy = (st_nxt.phase != 4'h0);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.ctrl <= `CTRL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata   = st_r.prdata;
  assign pready   = st_r.pready;
  assign pslverr  = st_r.pslverr;
  assign cfg_word = st_r.word;
  assign busy     = st_r.busy;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Ratio table corners
  a_ratio_plain: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_r.ctrl[`CTRL_DECOMP_BIT] && !st_r.ctrl[`CTRL_DECRYPT_BIT]) |-> ratio == 4'h1)
    else $error("ratio not 1 with both features off");

  a_ratio_wide: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.ctrl[`CTRL_DECOMP_BIT] && st_r.width == `WIDTH_32) |-> ratio == 4'h8)
    else $error("x32 decompress ratio not 8");

  a_ratio_byte_crypt: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_r.ctrl[`CTRL_DECOMP_BIT] && st_r.ctrl[`CTRL_DECRYPT_BIT]
      && st_r.width == `WIDTH_8) |-> ratio == 4'h1)
    else $error("x8 decrypt ratio not 1");

  a_word_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.word.valid && ratio > 4'h1 && $stable(st_r.ctrl)) |-> st_r.phase == 4'h1)
    else $error("phase did not advance after latch");

  a_lane_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.word.valid && st_r.width == `WIDTH_8) |-> st_r.word.data[31:8] == 24'h00_0000)
    else $error("unused lanes leaked in x8");

  a_width_hold: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.strap_done |=> $stable(st_r.width))
    else $error("width changed after strap capture");

  a_latch_rise: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.word.valid |-> $past(st_r.clk_s2) && !$past(st_r.clk_s3))
    else $error("word latched without rising edge");

  // Every setup cycle earns exactly one ready cycle
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("APB answer not one cycle after setup");

  // ----------------------------------------------------------------
  // Further ratio, intake and bus checks
  // ----------------------------------------------------------------
  // Remaining ratio table entries, one per width and feature mix
  a_ratio_byte_dc: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.ctrl[`CTRL_DECOMP_BIT] && st_r.width == `WIDTH_8) |-> ratio == 4'h2)
    else $error("x8 decompress ratio not 2");

  a_ratio_half_dc: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.ctrl[`CTRL_DECOMP_BIT] && st_r.width == `WIDTH_16) |-> ratio == 4'h4)
    else $error("x16 decompress ratio not 4");

  a_ratio_half_crypt: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_r.ctrl[`CTRL_DECOMP_BIT] && st_r.ctrl[`CTRL_DECRYPT_BIT]
      && st_r.width == `WIDTH_16) |-> ratio == 4'h2)
    else $error("x16 decrypt ratio not 2");

  a_ratio_wide_crypt: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_r.ctrl[`CTRL_DECOMP_BIT] && st_r.ctrl[`CTRL_DECRYPT_BIT]
      && st_r.width == `WIDTH_32) |-> ratio == 4'h4)
    else $error("x32 decrypt ratio not 4");

  // Phase never reaches the ratio, so every r-th edge latches
  a_phase_limit: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.phase < ratio)
    else $error("phase ran past the ratio");

  // A switched-off loader hands over nothing
  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !st_r.ctrl[`CTRL_ENABLE_BIT] |=> !st_r.word.valid)
    else $error("word latched while disabled");

  // A rising edge on phase zero raises the word strobe one edge later
  a_latch_phase: assert property (@(posedge pclk) disable iff (!presetn)
    (rise && st_r.strap_done && st_r.ctrl[`CTRL_ENABLE_BIT] && st_r.phase == 4'h0)
      |=> st_r.word.valid)
    else $error("phase zero edge did not latch");

  // Upper half lanes stay zero in x16
  a_lane_half: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.word.valid && st_r.width == `WIDTH_16) |-> st_r.word.data[31:16] == 16'h0000)
    else $error("unused lanes leaked in x16");

  // The error flag only ever stands beside pready
  a_err_pready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");

  // Straps are captured only after both sync stages have filled
  a_strap_wait: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r.strap_done) |-> $past(st_r.strap_wait) == 2'h2)
    else $error("straps captured before sync filled");

  // Each latch adds one to the word count unless a clear met it
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.word.valid && !$past(count_clear))
      |-> st_r.count == $past(st_r.count) + 32'h0000_0001)
    else $error("word count did not step by one");

  // A clear meeting a latch leaves the latched word counted
  a_count_race: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(count_clear) && st_r.word.valid) |-> st_r.count == 32'h0000_0001)
    else $error("count clear beat the latch");

  c_byte_word: cover property (@(posedge pclk) disable iff (!presetn)
    st_r.word.valid && st_r.width == `WIDTH_8);
  c_ratio_eight: cover property (@(posedge pclk) disable iff (!presetn)
    st_r.word.valid && ratio == 4'h8);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr);
  c_tail: cover property (@(posedge pclk) disable iff (!presetn)
    busy && !st_r.word.valid && rise);
  c_half_word: cover property (@(posedge pclk) disable iff (!presetn)
    st_r.word.valid && st_r.width == `WIDTH_16);

endmodule : parallel_config_clock_ratio

`default_nettype wire

// ===== sim/config_host.sv
// Host model that drives the config clock and data bus of the loader
`timescale 1ns/1ps
`default_nettype none
module config_host (
  input  wire logic        pclk,
  output logic             config_clock,
  output logic [31:0]      config_data
);
  // ------------------------------
  // Word transfer
  // ------------------------------
  // Clock stands low between frames
  initial begin
    config_clock = 1'b0;
    config_data  = 32'h0000_0000;
  end

  // Lanes outside the mask are driven with the inverted word
  task automatic send(input logic [31:0] w, input logic [31:0] m, input int r);
    config_data <= (w & m) | (~w & ~m);
    repeat (r) begin
      repeat (4) @(posedge pclk);
      config_clock <= 1'b1;
      repeat (4) @(posedge pclk);
      config_clock <= 1'b0;
    end
  endtask : send

  // Released bus no longer shows its last value
  task automatic release_bus;
    config_data <= ~config_data;
  endtask : release_bus
endmodule : config_host
`default_nettype wire

// ===== sim/parallel_config_clock_ratio_tb.sv
// Self-checking bench for the parallel config loader
`timescale 1ns/1ps
`default_nettype none
`include "parallel_config_params.svh"
module parallel_config_clock_ratio_tb;
  import parallel_config_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic         config_clock, err, busy_seen;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, config_data, rd, m, w;
  logic [1:0]   mode_select_straps;
  cfg_word_type cfg_word;
  int           miscompares, n_compared, n_valid, r;

  // ------------------------------
  // Instances and clock
  // ------------------------------
  parallel_config_clock_ratio parallel_config_clock_ratio_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_clock(config_clock), .config_data(config_data),
    .mode_select_straps(mode_select_straps), .cfg_word(cfg_word), .busy(busy));
  config_host config_host_i (.pclk(pclk), .config_clock(config_clock),
    .config_data(config_data));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Counts latched words and notes processing cycles
  always @(posedge pclk) begin
    if (cfg_word.valid === 1'b1) n_valid++;
    if (busy === 1'b1) busy_seen = 1'b1;
  end

  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for ready; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so a following call never re-raises psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic do_reset(input logic [1:0] s);
    mode_select_straps <= s;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : do_reset

  function automatic int exp_ratio(input int s, input logic dc, input logic de);
    if (!dc && !de) return 1;
    if (s == 0) return dc ? 2 : 1;
    if (s == 1) return dc ? 4 : 2;
    return dc ? 8 : 4;
  endfunction : exp_ratio

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // ------------------------------
  // Tests
  // ------------------------------
  // Every strap setting against every feature mix
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, mode_select_straps} = '0;
    {miscompares, n_compared, n_valid, busy_seen} = '0;
    @(posedge pclk);
    for (int s = 0; s < 4; s++) begin
      for (int f = 0; f < 4; f++) begin
        do_reset(2'(s));
        apb(1'b0, `OFS_CTRL, 32'h0000_0000, rd, err);
        chk("ctrl reset", rd, 32'h0000_0000);
        apb(1'b1, `OFS_CTRL, {29'h0, 2'(f), 1'b1}, rd, err);
        apb(1'b0, `OFS_CTRL, 32'h0000_0000, rd, err);
        chk("ctrl", rd, {29'h0, 2'(f), 1'b1});
        r = exp_ratio(s, f[0], f[1]);
        m = (s == 0) ? 32'h0000_00FF : (s == 1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        w = 32'h2468_ACE1 ^ 32'(f);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000, rd, err);
        chk("width", {30'h0, rd[1:0]}, (s == 3) ? 32'h0000_0002 : 32'(s));
        chk("ratio", {28'h0, rd[11:8]}, 32'(r));
        n_valid = 0;
        busy_seen = 1'b0;
        config_host_i.send(32'h9A3C_57E1, m, r);
        config_host_i.send(w, m, r);
        config_host_i.release_bus();
        repeat (6) @(posedge pclk);
        chk("valid pulses", 32'(n_valid), 32'h0000_0002);
        chk("busy seen", {31'h0, busy_seen}, {31'h0, r > 1});
        chk("word out", cfg_word.data, w & m);
        apb(1'b0, `OFS_COUNT, 32'h0000_0000, rd, err);
        chk("count", rd, 32'h0000_0002);
        apb(1'b0, `OFS_WORD, 32'h0000_0000, rd, err);
        chk("word reg", rd, w & m);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000, rd, err);
        chk("idle phase", {27'h0, rd[15:12], rd[2]}, 32'h0000_0000);
      end
    end
    // Unmapped place, count clear and loading switched off
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, rd, err);
    chk("unmapped write", {31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
    chk("unmapped read", {rd[31:1], err}, 32'h0000_0001);
    apb(1'b1, `OFS_COUNT, 32'h0000_0000, rd, err);
    apb(1'b1, `OFS_CTRL, 32'h0000_0000, rd, err);
    n_valid = 0;
    config_host_i.send(32'h1357_9BDF, 32'hFFFF_FFFF, 1);
    repeat (6) @(posedge pclk);
    chk("disabled pulses", 32'(n_valid), 32'h0000_0000);
    apb(1'b0, `OFS_COUNT, 32'h0000_0000, rd, err);
    chk("count cleared", rd, 32'h0000_0000);
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #2_000_000;
    miscompares++;
    end_of_test();
  end
endmodule : parallel_config_clock_ratio_tb
`default_nettype wire
